// file: logic/dptd_regs.vh
// Field positions, codes and reset values for the drive parameter telegram decoder
`ifndef DPTD_REGS_VH
`define DPTD_REGS_VH
`define DPTD_PNU_MSB 10
`define DPTD_CMD_LSB 12
`define DPTD_CMD_MSB 15
`define DPTD_CMD_NONE 4'h0
`define DPTD_CMD_READ 4'h1
`define DPTD_CMD_WR_W 4'h2
`define DPTD_CMD_WR_DW 4'h3
`define DPTD_CMD_WR_DW_NV 4'hd
`define DPTD_CMD_WR_W_NV 4'he
`define DPTD_CMD_TEXT 4'hf
`define DPTD_RSP_NONE 4'h0
`define DPTD_RSP_WORD 4'h1
`define DPTD_RSP_DWORD 4'h2
`define DPTD_RSP_FAIL 4'h7
`define DPTD_RSP_TEXT 4'hf
`define DPTD_FLT_NO_PARAM 32'h0000_0000
`define DPTD_FLT_NO_WRITE 32'h0000_0001
`define DPTD_FLT_BAD_INDEX 32'h0000_0003
`define DPTD_FLT_NOT_ARRAY 32'h0000_0004
`define DPTD_FLT_BAD_TYPE 32'h0000_0005
`define DPTD_TYPE_S16 4'h3
`define DPTD_TYPE_S32 4'h4
`define DPTD_TYPE_U8 4'h5
`define DPTD_TYPE_U16 4'h6
`define DPTD_TYPE_U32 4'h7
`define DPTD_TYPE_TEXT 4'h9
`define DPTD_PROFILE_DRIVE 8'h01
`define DPTD_FAULT_MIN 8'h01
`define DPTD_FAULT_MAX 8'h63
`define DPTD_CW_VALID 10
`define DPTD_CW_RESET 7
`define DPTD_CW_RESET_VAL 16'h0000
`define DPTD_TEXT_LEN_FIXED 8'h0a
`define DPTD_ELEM_MSB 7
`define DPTD_CW_PRESET_MSB 1
`define DPTD_CW_BRAKE 2
`define DPTD_CW_COAST 3
`define DPTD_CW_QSTOP 4
`define DPTD_CW_FREEZE 5
`define DPTD_CW_START 6
`define DPTD_CW_JOG 8
`define DPTD_CW_RAMP 9
`define DPTD_CW_DOUT 11
`define DPTD_CW_RELAY 12
`define DPTD_CW_SETUP_LSB 13
`define DPTD_CW_SETUP_MSB 14
`define DPTD_CW_REVERSE 15
`endif

// file: logic/dptd_decoder.v
// Drive parameter telegram data block decoder, device side
// What this block does
// - Parameter number sits in identifier bits 0 to 10.
// - Subindex is two bytes; only the low byte selects the element.
// - Error-code array reads return a fault code between 1 and 99.
// - Value field is two words; meaning depends on command code.
// - Read request value field is ignored; answer carries present value.
// - Enumerated options are written as their option number.
// - Text reads allowed only for text-type parameters.
// - Text telegram length is reported in the length byte.
// - Subindex distinguishes text read from text write.
// - Supported data types are 3,4,5,6,7 and 9.
// - Values travel as integers scaled by a conversion factor.
// - Conversion factor is one of eight powers of ten.
// - Process block: control word then reference; status then frequency.
// - Control word decoded only when profile setting equals 1.
// - Bits 2-5 low request brake, coast, quick stop, freeze; 6-8 start,reset,jog.
// - Bit 9 ramp, 10 valid, 11-12 outputs, 13-14 setup, 15 reverse.
// - Bits 1 and 0 select one of four preset references.
// - Command code in identifier bits 12 to 15 with listed encodings.
// - Failing command answers code 0111 with a fault number.
// - Whole control word ignored while bit 10 is zero.
// - Trip reset acts only on rising edge of bit 7.
`timescale 1ns/1ns
`include "dptd_regs.vh"
module dptd_decoder #(
    parameter PNU_W = 11,
    parameter ERR_PNU = 11'd615,
    parameter TEXT_SUB_WRITE = 8'h01
) (
    input wire mclk,
    input wire reset_n,
    // Request, words already assembled high byte first by the framer
    input wire req_valid,
    input wire [15:0] req_ident,
    input wire [15:0] req_subindex,
    input wire [15:0] req_value_hi,
    input wire [15:0] req_value_lo,
    input wire [15:0] req_process_word1,
    input wire [15:0] req_process_word2,
    input wire [7:0] req_length,
    // Parameter store lookup, answered combinationally on the same clock
    output wire [PNU_W-1:0] par_number,
    output wire [7:0] par_element,
    input wire par_exists,
    input wire par_writable,
    input wire par_is_array,
    input wire [3:0] par_type,
    input wire [2:0] par_factor_sel,
    input wire par_in_range,
    input wire [31:0] par_value,
    input wire [7:0] par_text_len,
    input wire [7:0] fault_code,
    // Write strobe toward the store
    output reg par_wr_stb,
    output reg par_wr_nonvol,
    output reg [31:0] par_wr_value,
    output reg par_text_wr_stb,
    // Configuration and drive state
    input wire [7:0] telegram_profile,
    input wire [15:0] drive_status_word,
    input wire [15:0] drive_output_freq,
    // Response
    output reg rsp_valid,
    output reg [15:0] rsp_ident,
    output reg [15:0] rsp_subindex,
    output reg [15:0] rsp_value_hi,
    output reg [15:0] rsp_value_lo,
    output reg [15:0] rsp_process_word1,
    output reg [15:0] rsp_process_word2,
    output reg [7:0] rsp_length,
    output reg [2:0] rsp_factor_sel,
    // Decoded control word
    output reg [15:0] reference_value,
    output reg [1:0] preset_ref_sel,
    output reg dc_brake_req,
    output reg coast_req,
    output reg quick_stop_req,
    output reg freeze_req,
    output reg start_req,
    output reg trip_reset_pulse,
    output reg jog_req,
    output reg ramp2_sel,
    output reg digital_out,
    output reg relay_out,
    output reg [1:0] setup_sel,
    output reg reverse_req
);

    reg [15:0] ctrl_word_reg;
    reg [15:0] ctrl_word_next;
    reg reset_bit_reg;
    reg [3:0] rsp_code;
    reg [31:0] rsp_val;
    reg do_write;
    reg do_text_wr;

    wire [3:0] cmd = req_ident[`DPTD_CMD_MSB:`DPTD_CMD_LSB];
    wire profile_on = (telegram_profile == `DPTD_PROFILE_DRIVE);
    wire cw_valid = req_process_word1[`DPTD_CW_VALID];
    // One accept term shared by the stored word, the reference and the trip edge
    wire cw_accept = req_valid && profile_on && cw_valid;
    // Only these two write commands also reach non-volatile memory
    wire wr_nonvol_cmd = (cmd == `DPTD_CMD_WR_DW_NV) || (cmd == `DPTD_CMD_WR_W_NV);
    // Text answers carry the fixed characters plus the text itself
    wire [7:0] text_rsp_len = `DPTD_TEXT_LEN_FIXED + par_text_len;

    assign par_number = req_ident[`DPTD_PNU_MSB:0];
    assign par_element = req_subindex[`DPTD_ELEM_MSB:0];

    // Data type is one of the supported codes
    function type_ok;
        input [3:0] t;
        begin
            type_ok = (t == `DPTD_TYPE_S16) || (t == `DPTD_TYPE_S32) ||
                (t == `DPTD_TYPE_U8) || (t == `DPTD_TYPE_U16) ||
                (t == `DPTD_TYPE_U32) || (t == `DPTD_TYPE_TEXT);
        end
    endfunction

    // Word-sized types answer with the word response code
    function is_word_type;
        input [3:0] t;
        begin
            is_word_type = (t == `DPTD_TYPE_S16) || (t == `DPTD_TYPE_U8) ||
                (t == `DPTD_TYPE_U16);
        end
    endfunction

    // Numeric answers report word or double word by data type
    function [3:0] num_rsp_code;
        input [3:0] t;
        begin
            if (is_word_type(t)) begin
                num_rsp_code = `DPTD_RSP_WORD;
            end else begin
                num_rsp_code = `DPTD_RSP_DWORD;
            end
        end
    endfunction

    // Numeric access needs a supported type other than text
    function numeric_type;
        input [3:0] t;
        begin
            numeric_type = type_ok(t) && (t != `DPTD_TYPE_TEXT);
        end
    endfunction

    // Clamp a fault code into the reportable 1..99 window
    function [7:0] clamp_fault;
        input [7:0] c;
        begin
            if (c < `DPTD_FAULT_MIN) begin
                clamp_fault = `DPTD_FAULT_MIN;
            end else if (c > `DPTD_FAULT_MAX) begin
                clamp_fault = `DPTD_FAULT_MAX;
            end else begin
                clamp_fault = c;
            end
        end
    endfunction

    // Command decode and answer selection; checks run in fault-number order, except text, which checks type before write access
    always @* begin
        rsp_code = `DPTD_RSP_NONE;
        rsp_val = 32'h0000_0000;
        do_write = 1'b0;
        do_text_wr = 1'b0;
        case (cmd)
            `DPTD_CMD_NONE: begin
                rsp_code = `DPTD_RSP_NONE;
            end
            `DPTD_CMD_READ: begin
                // Incoming value field is don't-care on a read
                if (!par_exists) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_NO_PARAM;
                end else if (par_is_array && !par_in_range) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_BAD_INDEX;
                end else if (!numeric_type(par_type)) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_BAD_TYPE;
                end else if (par_number == ERR_PNU) begin
                    rsp_code = `DPTD_RSP_WORD;
                    rsp_val = {24'h00_0000, clamp_fault(fault_code)};
                end else begin
                    rsp_code = num_rsp_code(par_type);
                    rsp_val = par_value;
                end
            end
            `DPTD_CMD_WR_W, `DPTD_CMD_WR_DW, `DPTD_CMD_WR_DW_NV, `DPTD_CMD_WR_W_NV: begin
                if (!par_exists) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_NO_PARAM;
                end else if (!par_writable) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_NO_WRITE;
                end else if (par_is_array && !par_in_range) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_BAD_INDEX;
                end else if (!numeric_type(par_type)) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_BAD_TYPE;
                end else begin
                    // Numbers and option numbers alike are stored raw
                    do_write = 1'b1;
                    rsp_code = num_rsp_code(par_type);
                    rsp_val = {req_value_hi, req_value_lo};
                end
            end
            `DPTD_CMD_TEXT: begin
                if (!par_exists) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_NO_PARAM;
                end else if (par_type != `DPTD_TYPE_TEXT) begin
                    rsp_code = `DPTD_RSP_FAIL;
                    rsp_val = `DPTD_FLT_BAD_TYPE;
                end else if (req_subindex[`DPTD_ELEM_MSB:0] == TEXT_SUB_WRITE) begin
                    // Subindex tells a text write from a text read
                    if (par_writable) begin
                        do_text_wr = 1'b1;
                        rsp_code = `DPTD_RSP_TEXT;
                    end else begin
                        rsp_code = `DPTD_RSP_FAIL;
                        rsp_val = `DPTD_FLT_NO_WRITE;
                    end
                end else begin
                    rsp_code = `DPTD_RSP_TEXT;
                end
            end
            default: begin
                rsp_code = `DPTD_RSP_FAIL;
                rsp_val = `DPTD_FLT_NO_PARAM;
            end
        endcase
    end

    // Control word taken only while its valid bit is set and profile selected
    always @* begin
        ctrl_word_next = ctrl_word_reg;
        if (cw_accept) begin
            ctrl_word_next = req_process_word1;
        end
    end

    // Response registers, one cycle after the request
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_ident <= 16'h0000;
            rsp_subindex <= 16'h0000;
            rsp_value_hi <= 16'h0000;
            rsp_value_lo <= 16'h0000;
            rsp_process_word1 <= 16'h0000;
            rsp_process_word2 <= 16'h0000;
            rsp_length <= 8'h00;
            rsp_factor_sel <= 3'h0;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_ident <= {rsp_code, 1'b0, par_number};
                rsp_subindex <= req_subindex;
                rsp_value_hi <= rsp_val[31:16];
                rsp_value_lo <= rsp_val[15:0];
                // Process words always in fixed order
                rsp_process_word1 <= drive_status_word;
                rsp_process_word2 <= drive_output_freq;
                rsp_factor_sel <= par_factor_sel;
                // Text reads grow with the text; other answers echo the request length
                if (rsp_code == `DPTD_RSP_TEXT && !do_text_wr) begin
                    rsp_length <= text_rsp_len;
                end else begin
                    rsp_length <= req_length;
                end
            end
        end
    end

    // Write strobes toward the store; data is held so the store may latch it late
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            par_wr_stb <= 1'b0;
            par_wr_nonvol <= 1'b0;
            par_wr_value <= 32'h0000_0000;
            par_text_wr_stb <= 1'b0;
        end else begin
            par_wr_stb <= req_valid && do_write;
            par_text_wr_stb <= req_valid && do_text_wr;
            if (req_valid) begin
                par_wr_nonvol <= wr_nonvol_cmd;
                par_wr_value <= {req_value_hi, req_value_lo};
            end
        end
    end

    // Accepted control word, reference and trip-reset edge
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_word_reg <= `DPTD_CW_RESET_VAL;
            reset_bit_reg <= 1'b0;
            trip_reset_pulse <= 1'b0;
            reference_value <= 16'h0000;
        end else begin
            ctrl_word_reg <= ctrl_word_next;
            trip_reset_pulse <= 1'b0;
            if (cw_accept) begin
                reference_value <= req_process_word2;
                // Edge is judged between accepted words only, so a steady 1 never repeats
                reset_bit_reg <= req_process_word1[`DPTD_CW_RESET];
                trip_reset_pulse <= req_process_word1[`DPTD_CW_RESET] && !reset_bit_reg;
            end
        end
    end

    // Decoded control outputs follow the stored word; stop requests are active low
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            preset_ref_sel <= 2'b00;
            dc_brake_req <= 1'b0;
            coast_req <= 1'b0;
            quick_stop_req <= 1'b0;
            freeze_req <= 1'b0;
            start_req <= 1'b0;
            jog_req <= 1'b0;
            ramp2_sel <= 1'b0;
            digital_out <= 1'b0;
            relay_out <= 1'b0;
            setup_sel <= 2'b00;
            reverse_req <= 1'b0;
        end else begin
            preset_ref_sel <= ctrl_word_next[`DPTD_CW_PRESET_MSB:0];
            dc_brake_req <= !ctrl_word_next[`DPTD_CW_BRAKE];
            coast_req <= !ctrl_word_next[`DPTD_CW_COAST];
            quick_stop_req <= !ctrl_word_next[`DPTD_CW_QSTOP];
            freeze_req <= !ctrl_word_next[`DPTD_CW_FREEZE];
            start_req <= ctrl_word_next[`DPTD_CW_START];
            jog_req <= ctrl_word_next[`DPTD_CW_JOG];
            ramp2_sel <= ctrl_word_next[`DPTD_CW_RAMP];
            digital_out <= ctrl_word_next[`DPTD_CW_DOUT];
            relay_out <= ctrl_word_next[`DPTD_CW_RELAY];
            setup_sel <= ctrl_word_next[`DPTD_CW_SETUP_MSB:`DPTD_CW_SETUP_LSB];
            reverse_req <= ctrl_word_next[`DPTD_CW_REVERSE];
        end
    end

endmodule

// file: testbench/dptd_chk.sv
// Port-level assertions for the drive parameter telegram decoder
`timescale 1ns/1ns
module dptd_chk #(
    parameter PNU_W = 11,
    parameter ERR_PNU = 11'd615
) (
    input wire mclk,
    input wire reset_n,
    input wire req_valid,
    input wire [15:0] req_ident,
    input wire [15:0] req_subindex,
    input wire [15:0] req_process_word1,
    input wire [7:0] telegram_profile,
    input wire [15:0] drive_status_word,
    input wire [15:0] drive_output_freq,
    input wire [PNU_W-1:0] par_number,
    input wire [7:0] par_element,
    input wire rsp_valid,
    input wire [15:0] rsp_ident,
    input wire [15:0] rsp_value_lo,
    input wire [15:0] rsp_process_word1,
    input wire [15:0] rsp_process_word2,
    input wire [1:0] preset_ref_sel,
    input wire [1:0] setup_sel,
    input wire reverse_req,
    input wire trip_reset_pulse
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Lookup fields come straight from the request words
    property p_pnu; par_number == req_ident[10:0]; endproperty
    a_pnu: assert property (p_pnu) else $error("parameter number slice wrong");
    property p_elem; par_element == req_subindex[7:0]; endproperty
    a_elem: assert property (p_elem) else $error("element selector wrong");
    // One answer per request, exactly one cycle later
    property p_lat; req_valid |=> rsp_valid; endproperty
    a_lat: assert property (p_lat) else $error("answer missing");
    property p_quiet; !req_valid |=> !rsp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_proc;
        req_valid |=> rsp_process_word1 == $past(drive_status_word)
            && rsp_process_word2 == $past(drive_output_freq);
    endproperty
    a_proc: assert property (p_proc) else $error("process words out of order");
    // Fault code reads stay inside 1..99
    property p_fault;
        rsp_valid && rsp_ident[15:12] == 4'h1 && rsp_ident[10:0] == ERR_PNU
            |-> rsp_value_lo >= 16'h0001 && rsp_value_lo <= 16'h0063;
    endproperty
    a_fault: assert property (p_fault) else $error("fault code out of range");
    // Control word with the valid bit low leaves reverse, setup and preset selection unchanged
    property p_ign;
        req_valid && !req_process_word1[10]
            |=> $stable(reverse_req) && $stable(setup_sel) && $stable(preset_ref_sel);
    endproperty
    a_ign: assert property (p_ign) else $error("invalid control word acted on");
    property p_dec;
        req_valid && telegram_profile == 8'h01 && req_process_word1[10]
            |=> reverse_req == $past(req_process_word1[15])
            && setup_sel == $past(req_process_word1[14:13])
            && preset_ref_sel == $past(req_process_word1[1:0]);
    endproperty
    a_dec: assert property (p_dec) else $error("control bits decoded wrongly");
    property p_trip; trip_reset_pulse |-> $past(req_valid) && $past(req_process_word1[7]);
    endproperty
    a_trip: assert property (p_trip) else $error("trip reset without cause");
    c_trip: cover property (trip_reset_pulse);
    c_fail: cover property (rsp_valid && rsp_ident[15:12] == 4'h7);
    c_text: cover property (rsp_valid && rsp_ident[15:12] == 4'hf);
endmodule
bind dptd_decoder dptd_chk #(.PNU_W(PNU_W), .ERR_PNU(ERR_PNU)) i_dptd_chk (
    .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_ident(req_ident),
    .req_subindex(req_subindex), .req_process_word1(req_process_word1),
    .telegram_profile(telegram_profile), .drive_status_word(drive_status_word),
    .drive_output_freq(drive_output_freq), .par_number(par_number), .par_element(par_element),
    .rsp_valid(rsp_valid), .rsp_ident(rsp_ident), .rsp_value_lo(rsp_value_lo),
    .rsp_process_word1(rsp_process_word1), .rsp_process_word2(rsp_process_word2),
    .preset_ref_sel(preset_ref_sel), .setup_sel(setup_sel), .reverse_req(reverse_req),
    .trip_reset_pulse(trip_reset_pulse)
);

// file: testbench/dptd_store.sv
// Parameter store model answering the decoder's lookups
`timescale 1ns/1ns
module dptd_store (
    input wire [10:0] par_number,
    input wire [7:0] par_element,
    input wire [3:0] num_type,
    output logic par_exists,
    output logic par_writable,
    output logic par_is_array,
    output logic par_in_range,
    output logic [3:0] par_type,
    output logic [2:0] par_factor_sel,
    output logic [31:0] par_value,
    output logic [7:0] par_text_len
);
    // Small fixed table; unknown numbers report absent
    always_comb begin
        {par_exists, par_writable, par_is_array} = 3'h0;
        par_in_range = 1'b1;
        par_type = 4'h6;
        par_factor_sel = 3'h2;
        par_value = 32'h0000_0000;
        par_text_len = 8'h08;
        case (par_number)
            11'd207: begin
                par_exists = 1'b1;
                par_factor_sel = 3'h3;
                par_value = 32'h0000_00a0;
            end
            11'd202: {par_exists, par_writable} = 2'h3;
            11'd100: begin
                par_exists = 1'b1;
                par_type = num_type;
                par_value = 32'h1234_5678;
            end
            11'd615: begin
                {par_exists, par_is_array} = 2'h3;
                par_type = 4'h5;
                par_in_range = par_element < 8'h06;
            end
            11'd621: begin
                {par_exists, par_writable} = 2'h3;
                par_type = 4'h9;
            end
            default: ;
        endcase
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the telegram decoder
`timescale 1ns/1ns
module tb_top;
    logic mclk = 0, reset_n = 0, req_valid = 0;
    logic [15:0] req_ident = 0, req_subindex = 0, req_value_hi = 0, req_value_lo = 0;
    logic [15:0] req_process_word1 = 0, req_process_word2 = 16'h1234;
    logic [7:0] req_length = 8'h0e, telegram_profile = 8'h01, fault_code = 0;
    logic [15:0] drive_status_word = 16'h0e07, drive_output_freq = 16'h01f4;
    logic [3:0] num_type = 4'h6;
    wire [10:0] par_number;
    wire [7:0] par_element, par_text_len, rsp_length;
    wire par_exists, par_writable, par_is_array, par_in_range;
    wire [3:0] par_type;
    wire [2:0] par_factor_sel, rsp_factor_sel;
    wire [31:0] par_value, par_wr_value;
    wire par_wr_stb, par_wr_nonvol, par_text_wr_stb, rsp_valid;
    wire [15:0] rsp_ident, rsp_subindex, rsp_value_hi, rsp_value_lo, reference_value;
    wire [15:0] rsp_process_word1, rsp_process_word2;
    wire [1:0] preset_ref_sel, setup_sel;
    wire dc_brake_req, coast_req, quick_stop_req, freeze_req, start_req, trip_reset_pulse;
    wire jog_req, ramp2_sel, digital_out, relay_out, reverse_req;
    wire [14:0] cw_out = {preset_ref_sel, dc_brake_req, coast_req, quick_stop_req, freeze_req,
        start_req, trip_reset_pulse, jog_req, ramp2_sel, digital_out, relay_out, setup_sel,
        reverse_req};
    int err_count = 0, check_count = 0, cycles = 0, i;
    logic [7:0] fin[3] = '{8'h00, 8'h2a, 8'hc8};
    logic [7:0] fex[3] = '{8'h01, 8'h2a, 8'h63};
    dptd_decoder i_dptd_decoder (.*);
    dptd_store i_dptd_store (.*);
    always #2 mclk = ~mclk;
    // Hang guard: the whole sequence needs well under 300 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        check_count++;
        if (e !== g) begin
            $display("BAD %s exp %h got %h", n, e, g);
            err_count++;
        end
    endtask
    // One request cycle; the answer is settled at the following falling edge
    task req(input [15:0] id, sb, lo, w1);
        @(negedge mclk);
        req_ident = id;
        req_subindex = sb;
        req_value_lo = lo;
        req_process_word1 = w1;
        req_valid = 1;
        @(negedge mclk);
        req_valid = 0;
    endtask
    task rd(input [15:0] id, sb, lo, rid, input [31:0] v);
        req(id, sb, lo, 16'h0000);
        chk("rsp_valid", 1, rsp_valid);
        chk("rsp_ident", rid, rsp_ident);
        chk("rsp_value", v, {rsp_value_hi, rsp_value_lo});
    endtask
    task cw(input [15:0] w1, input [14:0] e);
        req(16'h0000, 16'h0000, 16'h0000, w1);
        chk("control", e, cw_out);
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        reset_n = 1;
        rd(16'h10cf, 16'h0000, 16'hffff, 16'h10cf, 32'h0000_00a0);
        chk("factor", 3'h3, rsp_factor_sel);
        chk("length", 8'h0e, rsp_length);
        chk("status", 16'h0e07, rsp_process_word1);
        chk("freq", 16'h01f4, rsp_process_word2);
        rd(16'he0ca, 16'h0000, 16'h03e8, 16'h10ca, 32'h0000_03e8);
        chk("wr", 3'h7, {par_wr_stb, par_wr_nonvol, par_wr_value == 32'h3e8});
        rd(16'h20ca, 16'h0000, 16'h0014, 16'h10ca, 32'h0000_0014);
        chk("wr", 3'h5, {par_wr_stb, par_wr_nonvol, par_wr_value == 32'h14});
        req_value_hi = 16'h0001;
        rd(16'h30ca, 16'h0000, 16'h03e8, 16'h10ca, 32'h0001_03e8);
        chk("wr_dw", 3'h5, {par_wr_stb, par_wr_nonvol, par_wr_value == 32'h1_03e8});
        rd(16'hd0ca, 16'h0000, 16'h0002, 16'h10ca, 32'h0001_0002);
        chk("wr_dw_nv", 3'h7, {par_wr_stb, par_wr_nonvol, par_wr_value == 32'h1_0002});
        req_value_hi = 16'h0000;
        for (i = 0; i < 3; i++) begin
            fault_code = fin[i];
            rd(16'h1267, 16'hff01, 16'h0000, 16'h1267, {24'h0, fex[i]});
            chk("subindex", 16'hff01, rsp_subindex);
        end
        rd(16'h1267, 16'h0009, 16'h0000, 16'h7267, 32'h3);
        rd(16'h1005, 16'h0000, 16'h0000, 16'h7005, 32'h0);
        rd(16'h40cf, 16'h0000, 16'h0000, 16'h70cf, 32'h0);
        rd(16'h2064, 16'h0000, 16'h0001, 16'h7064, 32'h1);
        rd(16'hf0cf, 16'h0000, 16'h0000, 16'h70cf, 32'h5);
        rd(16'h126d, 16'h0000, 16'h0000, 16'h726d, 32'h5);
        req(16'hf26d, 16'h0000, 16'h0000, 16'h0000);
        chk("text_ident", 16'hf26d, rsp_ident);
        chk("text_len", 8'h12, rsp_length);
        req(16'hf26d, 16'h0001, 16'h0000, 16'h0000);
        chk("text_wr", 1, par_text_wr_stb);
        for (i = 3; i < 8; i++) begin
            num_type = i[3:0];
            req(16'h1064, 16'h0000, 16'h0000, 16'h0000);
            chk("type_code", (i == 4 || i == 7) ? 16'h2064 : 16'h1064, rsp_ident);
            chk("type_value", 32'h1234_5678, {rsp_value_hi, rsp_value_lo});
        end
        cw(16'h0400, 15'h1e00);
        chk("idle_ident", 16'h0000, rsp_ident);
        cw(16'hfffd, 15'h21ff);
        chk("reference", 16'h1234, reference_value);
        cw(16'hfffd, 15'h217f);
        cw(16'h0000, 15'h217f);
        telegram_profile = 8'h00;
        cw(16'h0400, 15'h217f);
        telegram_profile = 8'h01;
        for (i = 0; i < 4; i++)
            cw(16'h0400 | i[15:0], 15'h1e00 | (i[14:0] << 13));
        cw(16'h0480, 15'h1e80);
        conclude;
    end
endmodule
